/* design/dual_rail_vid_i2c_regs.sv */
// Purpose: serial-bus slave holding voltage codes and commands for two step-down rails
// Assumes: clk far faster than the bus clock; bus pins sampled and filtered on clk
// Notes:   the analog rails consume the field outputs; status flags come in as pins
//
// How it works
// - each received byte is acknowledged by holding data low over the next clock pulse
// - a register takes the data on the bus clock fall of the data byte's last bit
// - with both enable pins low the bus is ignored and nothing updates
// - rails off only by their command bits leaves the bus fully working
// - voltage register bits 6..0 hold the code, 10 mV per step from 0.68 V
// - voltage bit 7 is the apply bit; the code steers the rail only when set
// - command bits 6..4 pick the step rate, one step per 1 to 128 cycles
// - command bits 2..1 pick light-load behaviour: pin, fixed, auto, reserved
// - command bit 0 set turns the rail output off
// - only 7-bit addressing answers; no 10-bit or general call
// - status bit 2 over-temperature, bit 1 rail b good, bit 0 rail a good
// - the address pin sets the two low address bits above base 0x60
`timescale 1ns/10ps
module dual_rail_vid_i2c_regs
  import vid_regs_pkg::*;
(
  input  wire logic       clk,                   // system clock, 25 MHz
  input  wire logic       rst_n,                 // synchronous reset, active low
  input  wire logic       ce,                    // clock enable, freezes all state when low
  input  wire logic       scl_in,                // bus clock pin level
  input  wire logic       sda_in,                // bus data pin level
  output logic            sda_out,               // bus data drive value, always low
  output logic            sda_oe,                // bus data drive enable, high pulls low
  input  wire logic       rail_a_enable_pin,     // hardware enable of rail a
  input  wire logic       rail_b_enable_pin,     // hardware enable of rail b
  input  wire logic [1:0] addr_pin,              // address pin level: low, open, high
  input  wire logic       die_hot,               // die over-temperature warning
  input  wire logic       rail_a_in_regulation,  // rail a power good
  input  wire logic       rail_b_in_regulation,  // rail b power good
  output logic [6:0]      rail_a_voltage_target, // rail a code
  output logic            rail_a_apply_bit,      // rail a code steers the output
  output logic [2:0]      rail_a_slew_select,    // rail a step rate code
  output logic [1:0]      rail_a_light_load,     // rail a light-load select
  output logic            rail_a_off_bit,        // rail a output disabled
  output logic [6:0]      rail_b_voltage_target, // rail b code
  output logic            rail_b_apply_bit,      // rail b code steers the output
  output logic [2:0]      rail_b_slew_select,    // rail b step rate code
  output logic [1:0]      rail_b_light_load,     // rail b light-load select
  output logic            rail_b_off_bit         // rail b output disabled
);

  // ***********************************************************
  // pin synchronisers
  // ***********************************************************
  localparam int NPIN = 9;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_r;
  logic [NPIN-1:0] pin_s2_r;
  logic [NPIN-1:0] pin_s3_r;
  logic [NPIN-1:0] pin_f_r;
  logic [NPIN-1:0] pin_chg;
  assign pin_raw = {addr_pin, die_hot, rail_b_in_regulation, rail_a_in_regulation,
                    rail_b_enable_pin, rail_a_enable_pin, sda_in, scl_in};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      // a change counts only once the second and third stage agree
      assign pin_chg[gi] = (pin_s2_r[gi] == pin_s3_r[gi]) && (pin_s3_r[gi] != pin_f_r[gi]);
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          pin_s1_r[gi] <= 1'b1;
          pin_s2_r[gi] <= 1'b1;
          pin_s3_r[gi] <= 1'b1;
          pin_f_r[gi]  <= 1'b1;
        end else if (ce) begin
          pin_s1_r[gi] <= pin_raw[gi];
          pin_s2_r[gi] <= pin_s1_r[gi];
          pin_s3_r[gi] <= pin_s2_r[gi];
          if (pin_s2_r[gi] == pin_s3_r[gi]) begin
            pin_f_r[gi] <= pin_s3_r[gi];
          end
        end
      end
    end
  endgenerate
  logic       scl_f;
  logic       sda_f;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       hw_off;
  logic [6:0] dev_addr;
  assign scl_f     = pin_f_r[0];
  assign sda_f     = pin_f_r[1];
  assign scl_rise  = pin_chg[0] && !scl_f;
  assign scl_fall  = pin_chg[0] && scl_f;
  assign bus_start = pin_chg[1] && sda_f && scl_f && !pin_chg[0];
  assign bus_stop  = pin_chg[1] && !sda_f && scl_f && !pin_chg[0];
  assign hw_off    = !pin_f_r[2] && !pin_f_r[3];

  // ***********************************************************
  // slave address from the address pin
  // ***********************************************************
  always_comb begin
    // pin level picks low address bits
    if (pin_f_r[8:7] == ADDR_PIN_HIGH) begin
      dev_addr = SLAVE_ADDR_BASE + ADDR_OFS_HIGH;
    end else if (pin_f_r[8:7] == ADDR_PIN_OPEN) begin
      dev_addr = SLAVE_ADDR_BASE + ADDR_OFS_OPEN;
    end else begin
      dev_addr = SLAVE_ADDR_BASE + ADDR_OFS_LOW;
    end
  end

  // ***********************************************************
  // register file and read mux
  // ***********************************************************
  logic [7:0] code_r [2];
  logic [7:0] cmd_r  [2];
  logic [7:0] status_v;
  logic [7:0] rd_data;
  logic [7:0] ptr_r;
  logic [7:0] sh_r;
  logic       wr_commit;
  always_comb begin
    status_v             = 8'h00;
    status_v[HOT_BIT]    = pin_f_r[6];
    status_v[GOOD_B_BIT] = pin_f_r[5];
    status_v[GOOD_A_BIT] = pin_f_r[4];
  end
  always_comb begin
    if (ptr_r == OFS_RAIL_A_VOLTAGE_CODE) begin
      rd_data = code_r[0];
    end else if (ptr_r == OFS_RAIL_B_VOLTAGE_CODE) begin
      rd_data = code_r[1];
    end else if (ptr_r == OFS_RAIL_A_COMMAND) begin
      rd_data = cmd_r[0];
    end else if (ptr_r == OFS_RAIL_B_COMMAND) begin
      rd_data = cmd_r[1];
    end else if (ptr_r == OFS_SYSTEM_HEALTH_FLAGS) begin
      rd_data = status_v;
    end else begin
      rd_data = 8'h00;
    end
  end
  generate
    for (gi = 0; gi < 2; gi++) begin : g_rail
      localparam logic [7:0] OFS_CODE = gi ? OFS_RAIL_B_VOLTAGE_CODE : OFS_RAIL_A_VOLTAGE_CODE;
      localparam logic [7:0] OFS_CMD  = gi ? OFS_RAIL_B_COMMAND : OFS_RAIL_A_COMMAND;
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          code_r[gi] <= VOLTAGE_RST;
          cmd_r[gi]  <= COMMAND_RST;
        end else if (ce && wr_commit) begin
          // update at the last data bit's fall
          if (ptr_r == OFS_CODE) begin
            code_r[gi] <= sh_r;
          end
          if (ptr_r == OFS_CMD) begin
            cmd_r[gi] <= sh_r & COMMAND_MASK;
          end
        end
      end
    end
  endgenerate

  assign rail_a_voltage_target = code_r[0][CODE_MSB:0];
  assign rail_b_voltage_target = code_r[1][CODE_MSB:0];
  assign rail_a_apply_bit      = code_r[0][APPLY_BIT];
  assign rail_b_apply_bit      = code_r[1][APPLY_BIT];
  // step rate, light load, off bit
  assign rail_a_slew_select    = cmd_r[0][SLEW_MSB:SLEW_LSB];
  assign rail_b_slew_select    = cmd_r[1][SLEW_MSB:SLEW_LSB];
  assign rail_a_light_load     = cmd_r[0][LIGHT_LOAD_MSB:LIGHT_LOAD_LSB];
  assign rail_b_light_load     = cmd_r[1][LIGHT_LOAD_MSB:LIGHT_LOAD_LSB];
  assign rail_a_off_bit        = cmd_r[0][OFF_BIT];
  assign rail_b_off_bit        = cmd_r[1][OFF_BIT];
  assign sda_out               = 1'b0;

  // ***********************************************************
  // bus protocol engine
  // ***********************************************************
  bus_state_type state_r;
  logic [3:0]    cnt_r;
  logic [7:0]    tx_r;
  logic          rw_r;

  assign wr_commit = !hw_off && scl_fall && state_r == ST_WR_DATA && cnt_r == BITS_PER_BYTE;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r   <= 4'h0;
      sh_r    <= 8'h00;
      tx_r    <= 8'h00;
      ptr_r   <= 8'h00;
      rw_r    <= 1'b0;
      sda_oe  <= 1'b0;
    end else if (ce) begin
      if (hw_off) begin
        state_r <= ST_IDLE;
        sda_oe  <= 1'b0;
      end else if (bus_start) begin
        // start or repeated start begins addressing
        state_r <= ST_DEV_ADDR;
        cnt_r   <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (bus_stop) begin
        state_r <= ST_IDLE;
        sda_oe  <= 1'b0;
      end else if (scl_rise) begin
        if (state_r == ST_DEV_ADDR || state_r == ST_REG_ADDR || state_r == ST_WR_DATA) begin
          sh_r  <= {sh_r[6:0], sda_f};
          cnt_r <= cnt_r + 4'h1;
        end else if (state_r == ST_RD_DATA) begin
          cnt_r <= cnt_r + 4'h1;
        end else if (state_r == ST_RD_ACK) begin
          // master answer kept for the next fall
          rw_r <= !sda_f;
        end
      end else if (scl_fall) begin
        case (state_r)
          ST_DEV_ADDR: begin
            if (cnt_r == BITS_PER_BYTE) begin
              // only an exact 7-bit match is answered
              if (sh_r[7:1] == dev_addr) begin
                state_r <= ST_ACK_DEV;
                rw_r    <= sh_r[0];
                sda_oe  <= 1'b1;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
          ST_ACK_DEV: begin
            cnt_r <= 4'h0;
            if (rw_r) begin
              // first data bit goes out on this fall
              state_r <= ST_RD_DATA;
              tx_r    <= rd_data;
              sda_oe  <= !rd_data[7];
            end else begin
              state_r <= ST_REG_ADDR;
              sda_oe  <= 1'b0;
            end
          end
          ST_REG_ADDR: begin
            if (cnt_r == BITS_PER_BYTE) begin
              ptr_r   <= sh_r;
              state_r <= ST_ACK_REG;
              sda_oe  <= 1'b1;
            end
          end
          ST_WR_DATA: begin
            if (cnt_r == BITS_PER_BYTE) begin
              state_r <= ST_ACK_WR;
              sda_oe  <= 1'b1;
            end
          end
          ST_ACK_REG, ST_ACK_WR: begin
            state_r <= ST_WR_DATA;
            cnt_r   <= 4'h0;
            sda_oe  <= 1'b0;
          end
          ST_RD_DATA: begin
            if (cnt_r == BITS_PER_BYTE) begin
              state_r <= ST_RD_ACK;
              sda_oe  <= 1'b0;
            end else begin
              tx_r   <= {tx_r[6:0], 1'b0};
              sda_oe <= !tx_r[6];
            end
          end
          ST_RD_ACK: begin
            cnt_r <= 4'h0;
            if (rw_r) begin
              // master acknowledged: send the same register again
              state_r <= ST_RD_DATA;
              tx_r    <= rd_data;
              sda_oe  <= !rd_data[7];
            end else begin
              state_r <= ST_IDLE;
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  a_ack_driven: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_r == ST_ACK_DEV || state_r == ST_ACK_REG || state_r == ST_ACK_WR) |-> sda_oe)
    else $error("acknowledge slot without data pulled low");
  a_commit_edge: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ce && wr_commit && ptr_r == OFS_RAIL_A_VOLTAGE_CODE) |=> (code_r[0] == $past(sh_r)))
    else $error("voltage register did not take the data byte");
  a_hw_quiet: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ce && hw_off) |=> ($stable(code_r[0]) && $stable(code_r[1]) && $stable(cmd_r[0])
      && $stable(cmd_r[1]) && !sda_oe))
    else $error("activity during hardware shutdown");
  a_sw_alive: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ce && !hw_off && bus_start && cmd_r[0][OFF_BIT] && cmd_r[1][OFF_BIT])
      |=> state_r == ST_DEV_ADDR)
    else $error("bus dead in software shutdown");
  a_code_field: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ce && wr_commit && ptr_r == OFS_RAIL_B_VOLTAGE_CODE)
      |=> (rail_b_voltage_target == $past(sh_r[6:0])) && (rail_b_apply_bit == $past(sh_r[7])))
    else $error("code or apply field misplaced");
  a_reserved_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cmd_r[0][7] == 1'b0) && (cmd_r[1][3] == 1'b0) && (status_v[7:3] == 5'h00))
    else $error("reserved bit reads as one");
  a_addr_match: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_r == ST_ACK_DEV && $past(state_r) != ST_ACK_DEV)
      |-> ($past(sh_r[7:1]) == $past(dev_addr)))
    else $error("acknowledged a foreign address");
  a_read_load: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ce && !hw_off && !bus_start && !bus_stop && scl_fall && state_r == ST_ACK_DEV && rw_r
      && ptr_r == OFS_SYSTEM_HEALTH_FLAGS) |=> (tx_r == $past(status_v)))
    else $error("status byte not loaded for read");
endmodule

/* design/vid_regs_pkg.sv */
// Purpose: shared constants and types for the dual rail voltage-code register bank
// Assumes: byte wide registers reached over a two wire serial bus
// Notes:   offsets, field positions and reset values live here only
package vid_regs_pkg;

  // ***********************************************************
  // register offsets
  // ***********************************************************
  localparam logic [7:0] OFS_RAIL_A_VOLTAGE_CODE = 8'h00;
  localparam logic [7:0] OFS_RAIL_B_VOLTAGE_CODE = 8'h01;
  localparam logic [7:0] OFS_RAIL_A_COMMAND      = 8'h02;
  localparam logic [7:0] OFS_RAIL_B_COMMAND      = 8'h03;
  localparam logic [7:0] OFS_SYSTEM_HEALTH_FLAGS = 8'h04;

  // ***********************************************************
  // field layout and reset values
  // ***********************************************************
  localparam int         APPLY_BIT       = 7;
  localparam int         CODE_MSB        = 6;
  localparam int         SLEW_MSB        = 6;
  localparam int         SLEW_LSB        = 4;
  localparam int         LIGHT_LOAD_MSB  = 2;
  localparam int         LIGHT_LOAD_LSB  = 1;
  localparam int         OFF_BIT         = 0;
  localparam logic [7:0] COMMAND_MASK    = 8'h77;
  localparam logic [7:0] VOLTAGE_RST     = 8'h00;
  localparam logic [7:0] COMMAND_RST     = 8'h00;
  localparam int         HOT_BIT         = 2;
  localparam int         GOOD_B_BIT      = 1;
  localparam int         GOOD_A_BIT      = 0;

  // ***********************************************************
  // bus addressing and framing
  // ***********************************************************
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h60;
  localparam logic [1:0] ADDR_PIN_LOW    = 2'h0;
  localparam logic [1:0] ADDR_PIN_OPEN   = 2'h1;
  localparam logic [1:0] ADDR_PIN_HIGH   = 2'h2;
  localparam logic [6:0] ADDR_OFS_LOW    = 7'h00;
  localparam logic [6:0] ADDR_OFS_OPEN   = 7'h01;
  localparam logic [6:0] ADDR_OFS_HIGH   = 7'h02;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam int         SYNC_STAGES     = 3;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEV_ADDR,
    ST_ACK_DEV,
    ST_REG_ADDR,
    ST_ACK_REG,
    ST_WR_DATA,
    ST_ACK_WR,
    ST_RD_DATA,
    ST_RD_ACK
  } bus_state_type;

endpackage

/* verification/serial_host_model.sv */
// Purpose: behavioural bus host that frames writes and reads for the register bank
// Assumes: open-drain data line with a pull-up, resolved by the bench
// Notes:   one bus bit is 8 clk (320 ns); the clock is high for only 2 clk, so the
//          device's filtered, delayed answer lands well before each rising edge
`timescale 1ns/10ps
module serial_host_model (
  input  wire logic        clk,       // system clock
  input  wire logic        sda_line,  // resolved data line level
  output logic             scl,       // bus clock, held high between frames
  output logic             sda_low,   // high pulls the data line low
  output logic             got_valid, // one clk pulse per finished transfer
  output logic [15:0]      got        // acks of the three bytes and read data
);
  logic [7:0] rx_r;
  logic       nack_r;

  initial begin
    scl       = 1'b1;
    sda_low   = 1'b0;
    got_valid = 1'b0;
    got       = 16'h0000;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  // data changes mid low phase; the line is sampled at the end of the high phase
  task automatic put_bit(input logic b, output logic seen);
    sda_low = ~b;
    tick(4);
    scl = 1'b1;
    tick(2);
    seen = sda_line;
    scl = 1'b0;
    tick(2);
  endtask

  task automatic put_byte(input logic [7:0] d, input int nbits, output logic acked);
    logic seen;
    for (int i = 7; i > 7 - nbits; i--) begin
      put_bit(d[i], seen);
    end
    acked = 1'b0;
    if (nbits == 8) begin
      put_bit(1'b1, seen);
      acked = ~seen;
    end
  endtask

  // read byte closed by a not-acknowledge
  task automatic get_byte(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, d[i]);
    end
    put_bit(1'b1, nack_r);
  endtask

  task automatic start_cond(input logic again);
    if (again) begin
      sda_low = 1'b0;
      tick(4);
      scl = 1'b1;
    end
    tick(6);
    sda_low = 1'b1;
    tick(6);
    scl = 1'b0;
    tick(2);
  endtask

  task automatic stop_cond();
    sda_low = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(6);
    sda_low = 1'b0;
    tick(6);
  endtask

  task automatic xfer(input logic [6:0] dev, input logic rd, input logic [7:0] ofs,
                      input logic [7:0] data, input int nbits);
    logic a0, a1, a2;
    a1   = 1'b0;
    a2   = 1'b0;
    rx_r = 8'h00;
    start_cond(1'b0);
    put_byte({dev, 1'b0}, 8, a0);
    if (a0) put_byte(ofs, 8, a1);
    if (a1 && rd) begin
      start_cond(1'b1);
      put_byte({dev, 1'b1}, 8, a2);
      if (a2) get_byte(rx_r);
    end else if (a1) begin
      put_byte(data, nbits, a2);
    end
    // a refused or cut transfer still ends with a stop, as a real host would
    stop_cond();
    got       = {5'h00, a0, a1, a2, rx_r};
    got_valid = 1'b1;
    tick(1);
    got_valid = 1'b0;
  endtask
endmodule

/* verification/dual_rail_vid_i2c_regs_test.sv */
// Purpose: self-checking bench for the dual rail voltage-code register bank
// Assumes: bus host model drives the serial pins; status pins driven directly
// Notes:   clock enable is dropped once to show that a frozen block ignores the bus
`timescale 1ns/10ps
module dual_rail_vid_i2c_regs_test import vid_regs_pkg::*;;
  logic        clk, rst_n, scl, sda_low, sda_line, sda_out, sda_oe, got_valid, ce;
  logic        en_a, en_b, die_hot, good_a, good_b, a_apply, b_apply, a_off, b_off;
  logic [1:0]  addr_pin, a_ll, b_ll;
  logic [2:0]  a_slew, b_slew;
  logic [6:0]  a_code, b_code, dev;
  logic [6:0]  bad [3];
  logic [7:0]  v;
  logic [7:0]  sh [5];
  logic [15:0] got, view_a, view_b;
  logic [15:0] exp_q [$];
  int          errors, checks, seed;

  assign sda_line = ~(sda_low | (sda_oe & ~sda_out));
  assign view_a   = {a_apply, a_code, 1'b0, a_slew, 1'b0, a_ll, a_off};
  assign view_b   = {b_apply, b_code, 1'b0, b_slew, 1'b0, b_ll, b_off};

  dual_rail_vid_i2c_regs uut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .rail_a_enable_pin(en_a), .rail_b_enable_pin(en_b),
    .addr_pin(addr_pin), .die_hot(die_hot), .rail_a_in_regulation(good_a),
    .rail_b_in_regulation(good_b), .rail_a_voltage_target(a_code), .rail_a_apply_bit(a_apply),
    .rail_a_slew_select(a_slew), .rail_a_light_load(a_ll), .rail_a_off_bit(a_off),
    .rail_b_voltage_target(b_code), .rail_b_apply_bit(b_apply),
    .rail_b_slew_select(b_slew), .rail_b_light_load(b_ll), .rail_b_off_bit(b_off));

  serial_host_model mst (
    .clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low),
    .got_valid(got_valid), .got(got));

  // ***********************************************************
  // shared tasks
  // ***********************************************************
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d, input logic [2:0] acks,
                    input int nbits);
    exp_q.push_back({5'h00, acks, 8'h00});
    mst.xfer(dev, 1'b0, ofs, d, nbits);
  endtask

  task automatic rd(input logic [7:0] ofs, input logic [7:0] want);
    exp_q.push_back({5'h00, 3'h7, want});
    mst.xfer(dev, 1'b1, ofs, 8'h00, 8);
  endtask

  task automatic views();
    check(view_a, {sh[0], sh[2]});
    check(view_b, {sh[1], sh[3]});
  endtask

  // reserved command bits never reach the shadow copy
  task automatic wr_ok(input logic [7:0] ofs, input logic [7:0] d);
    if (ofs < 8'h02) sh[ofs[2:0]] = d;
    else if (ofs < 8'h04) sh[ofs[2:0]] = d & COMMAND_MASK;
    wr(ofs, d, 3'h7, 8);
    views();
  endtask

  // ***********************************************************
  // clock, result watcher and hang guard
  // ***********************************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (got_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("mismatch at %0t: transfer result with nothing expected", $time);
      end else begin
        check(got, exp_q.pop_front());
      end
    end
  end

  initial begin
    step(100000);
    errors++;
    $display("mismatch at %0t: run did not finish", $time);
    summarize();
  end

  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    rst_n    = 1'b0;
    ce       = 1'b1;
    en_a     = 1'b1;
    en_b     = 1'b1;
    addr_pin = ADDR_PIN_LOW;
    die_hot  = 1'b0;
    good_a   = 1'b0;
    good_b   = 1'b0;
    dev      = SLAVE_ADDR_BASE;
    bad      = '{SLAVE_ADDR_BASE, 7'h00, 7'h78};
    sh       = '{default: 8'h00};
    errors   = 0;
    checks   = 0;
    seed     = $urandom(32'h460E);
    step(20);
    rst_n = 1'b1;
    step(4);
    views();
    for (int i = 0; i < 5; i++) rd(8'(i), 8'h00);
    $display("test reset values done");
    for (int r = 0; r < 2; r++) begin
      v = 8'($urandom);
      wr_ok(8'(r), {1'b1, v[6:0]});
      rd(8'(r), sh[r]);
      wr_ok(8'(r), 8'h7F);
    end
    $display("test voltage codes done");
    for (int s = 0; s < 8; s++) begin
      v = {1'b1, 3'(s), 1'b1, 2'(s), s[0]};
      wr_ok(OFS_RAIL_A_COMMAND, v);
      wr_ok(OFS_RAIL_B_COMMAND, ~v);
      rd(OFS_RAIL_A_COMMAND, sh[2]);
    end
    // both rails off by their command bits: the bus must keep working
    wr_ok(OFS_RAIL_B_COMMAND, 8'h01);
    wr_ok(OFS_RAIL_B_VOLTAGE_CODE, 8'($urandom));
    rd(OFS_RAIL_B_VOLTAGE_CODE, sh[1]);
    $display("test command fields done");
    for (int k = 0; k < 8; k++) begin
      {die_hot, good_b, good_a} = 3'(k);
      step(6);
      rd(OFS_SYSTEM_HEALTH_FLAGS, 8'(k));
    end
    wr(OFS_SYSTEM_HEALTH_FLAGS, 8'hFF, 3'h7, 8);
    rd(OFS_SYSTEM_HEALTH_FLAGS, 8'h07);
    $display("test status flags done");
    for (int p = 0; p < 3; p++) begin
      addr_pin = 2'(p);
      dev      = SLAVE_ADDR_BASE + 7'(p);
      step(6);
      wr_ok(OFS_RAIL_A_VOLTAGE_CODE, 8'($urandom));
    end
    for (int b = 0; b < 3; b++) begin
      dev = bad[b];
      wr(OFS_RAIL_A_VOLTAGE_CODE, 8'h55, 3'h0, 8);
      views();
    end
    dev = SLAVE_ADDR_BASE + ADDR_OFS_HIGH;
    $display("test addressing done");
    en_a = 1'b0;
    en_b = 1'b0;
    step(6);
    wr(OFS_RAIL_B_VOLTAGE_CODE, 8'hAA, 3'h0, 8);
    views();
    en_a = 1'b1;
    step(6);
    wr_ok(OFS_RAIL_B_VOLTAGE_CODE, 8'hAA);
    // a data byte cut before its last bit must not update anything
    wr(OFS_RAIL_B_VOLTAGE_CODE, 8'h33, 3'h6, 7);
    views();
    // with the clock enable low every flop holds, so a whole write must pass unseen
    ce = 1'b0;
    step(2);
    wr(OFS_RAIL_A_COMMAND, 8'h10, 3'h0, 8);
    views();
    ce = 1'b1;
    step(6);
    $display("test shutdown and cut byte done");
    for (int w = 0; w < 50 && exp_q.size() != 0; w++) step(1);
    if (exp_q.size() != 0) begin
      errors++;
      $display("mismatch at %0t: transfer results missing", $time);
    end
    summarize();
  end
endmodule
